// ==== bench/bct_assertions.sv ====
// Port checker for the bus condition timing block.
module bct_assertions (
    input wire logic        CLK,
    input wire logic        RESET_N,
    input wire logic [31:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [15:0] RDATA,
    input wire logic [2:0]  PRESCALE,
    input wire logic        BUS_OCCUPIED,
    input wire logic        START_DET,
    input wire logic        STOP_DET
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wpre;
    logic       tw;
    assign wpre = WDATA[11:9];
    assign tw = WR && ADDR == bct_pkg::BUS_TIMING_CONTROL_ADDR;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    sequence s_tr; RD && ADDR == bct_pkg::BUS_TIMING_CONTROL_ADDR; endsequence
    sequence s_clr; WR && ADDR == bct_pkg::SHARED_CONTROL_ADDR && WDATA[0]; endsequence
    property p_pre_wr; tw |-> ##2 PRESCALE == $past(wpre, 2); endproperty
    property p_pre_hold; !tw && !$past(tw) |=> $stable(PRESCALE); endproperty
    property p_rd_idle; !$past(RD) |-> RDATA == 16'h0000; endproperty
    property p_rsvd; s_tr |=> RDATA[7:6] == 2'b00; endproperty
    property p_clr; s_clr |=> ##[0:2] !BUS_OCCUPIED; endproperty
    property p_start1; START_DET |=> !START_DET; endproperty
    property p_stop1; STOP_DET |=> !STOP_DET; endproperty
    property p_excl; !(START_DET && STOP_DET); endproperty
    a_pre_wr: assert property (p_pre_wr) else $error("prescale not taken");
    a_pre_hold: assert property (p_pre_hold) else $error("prescale moved");
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    a_clr: assert property (p_clr) else $error("occupied not cleared");
    a_start1: assert property (p_start1) else $error("start pulse long");
    a_stop1: assert property (p_stop1) else $error("stop pulse long");
    a_excl: assert property (p_excl) else $error("start and stop together");
endmodule

bind bct_top bct_assertions bct_assertions_i (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .PRESCALE(PRESCALE), .BUS_OCCUPIED(BUS_OCCUPIED),
    .START_DET(START_DET), .STOP_DET(STOP_DET));

// ==== bench/bct_bus_model.sv ====
// Model of the other devices on the two-wire bus, open drain with pull-ups.
module bct_bus_model (
    input wire logic clk,
    output logic     scl,
    output logic     sda
);
    timeunit 1ns;
    timeprecision 1ps;
    logic scl_oe = 1'b0;
    logic sda_oe = 1'b0;
    // Released lines float to the pull-up level, never to a stale value.
    assign scl = !scl_oe;
    assign sda = !sda_oe;
    task automatic start_cond(input int hold);
        sda_oe <= 1'b1;
        repeat (hold) @(posedge clk);
        scl_oe <= 1'b1;
        repeat (20) @(posedge clk);
    endtask
    task automatic stop_cond(input int hold);
        scl_oe <= 1'b0;
        repeat (hold) @(posedge clk);
        sda_oe <= 1'b0;
        repeat (20) @(posedge clk);
    endtask
    task automatic glitch(input int n);
        sda_oe <= 1'b1;
        repeat (n) @(posedge clk);
        sda_oe <= 1'b0;
        repeat (20) @(posedge clk);
    endtask
endmodule

// ==== bench/bct_top_tb.sv ====
// Self-checking testbench for the bus condition timing block.
module bct_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] TA = bct_pkg::BUS_TIMING_CONTROL_ADDR;
    localparam logic [31:0] SA = bct_pkg::SHARED_CONTROL_ADDR;
    typedef struct { logic [31:0] a; logic [15:0] d; logic [15:0] q; logic [2:0] p; } bct_row_t;
    bct_row_t    rows[4] = '{'{TA, 16'hffff, 16'hff3f, 3'h7}, '{TA, 16'h1ac5, 16'h1a05, 3'h5},
                             '{SA, 16'h0001, 16'h0000, 3'h5}, '{32'h4002_0860, 16'hffff, 16'h0000, 3'h5}};
    logic        CLK, RESET_N, WR, RD;
    logic [31:0] ADDR;
    logic [15:0] WDATA, RDATA, rv;
    logic [2:0]  PRESCALE;
    logic        SCL_IN, SDA_IN, BUS_OCCUPIED, START_DET, STOP_DET;
    int          num_errors = 0, n_checks = 0, n_start = 0, n_stop = 0, cyc = 0;
    bct_top bct_top_i (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .PRESCALE(PRESCALE),
        .BUS_OCCUPIED(BUS_OCCUPIED), .START_DET(START_DET), .STOP_DET(STOP_DET));
    bct_bus_model bct_bus_model_i (.clk(CLK), .scl(SCL_IN), .sda(SDA_IN));
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        cyc++;
        if (START_DET === 1'b1) n_start++;
        if (STOP_DET === 1'b1) n_stop++;
        if (cyc == 5000) begin
            num_errors++;
            print_verdict();
        end
    end
    task automatic check(input string name, input logic [15:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [15:0] d);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        RESET_N = 1'b0;
        WR = 1'b0;
        RD = 1'b0;
        ADDR = 32'h0000_0000;
        WDATA = 16'h0000;
        repeat (10) @(posedge CLK);
        RESET_N <= 1'b1;
        repeat (3) @(posedge CLK);
        rd(TA, rv);
        check("timing reset", rv, 16'h0205);
        rd(SA, rv);
        check("shared reset", rv, 16'h0000);
        check("prescale reset", {13'h0, PRESCALE}, 16'h0001);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rv);
            check("readback", rv, rows[i].q);
            check("prescale", {13'h0, PRESCALE}, {13'h0, rows[i].p});
        end
        wr(SA, 16'h0000);
        wr(TA, 16'h0005);
        $display("test registers done");
        bct_bus_model_i.start_cond(10);
        check("start count", 16'(n_start), 16'h0001);
        check("occupied", {15'h0, BUS_OCCUPIED}, 16'h0001);
        rd(bct_pkg::STATUS_ADDR, rv);
        check("status occupied", rv, 16'h0001);
        wr(SA, 16'h0001);
        repeat (3) @(posedge CLK);
        check("occupied cleared", {15'h0, BUS_OCCUPIED}, 16'h0000);
        wr(SA, 16'h0000);
        bct_bus_model_i.stop_cond(10);
        check("stop count", 16'(n_stop), 16'h0001);
        bct_bus_model_i.start_cond(3);
        check("short hold", 16'(n_start), 16'h0001);
        bct_bus_model_i.stop_cond(10);
        bct_bus_model_i.glitch(2);
        check("bypass", 16'(n_stop), 16'h0003);
        $display("test conditions done");
        wr(TA, 16'h4105);
        bct_bus_model_i.glitch(2);
        check("filtered", 16'(n_stop), 16'h0003);
        $display("test filter done");
        RESET_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RESET_N <= 1'b1;
        repeat (3) @(posedge CLK);
        rd(TA, rv);
        check("timing after reset", rv, bct_pkg::BUS_TIMING_RESET);
        check("prescale after reset", {13'h0, PRESCALE}, 16'h0001);
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule

// ==== core/bct_condition_detect.sv ====
// Start and stop condition detector with hold-time qualification.
module bct_condition_detect (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       det_reset,
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic [5:0] hold_threshold,
    output logic            start_pulse,
    output logic            stop_pulse,
    output logic            occupied
);
    typedef enum logic [1:0] {IDLE, START_HOLD, STOP_HOLD} bct_det_state_t;
    bct_det_state_t state;
    logic           scl_d;
    logic           sda_d;
    logic [5:0]     hold_count;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state       <= IDLE;
            scl_d       <= 1'b1;
            sda_d       <= 1'b1;
            hold_count  <= 6'h00;
            start_pulse <= 1'b0;
            stop_pulse  <= 1'b0;
        end else if (det_reset) begin
            state       <= IDLE;
            scl_d       <= scl;
            sda_d       <= sda;
            hold_count  <= 6'h00;
            start_pulse <= 1'b0;
            stop_pulse  <= 1'b0;
        end else begin
            scl_d       <= scl;
            sda_d       <= sda;
            start_pulse <= 1'b0;
            stop_pulse  <= 1'b0;
            unique case (state)
                IDLE: begin
                    hold_count <= 6'h00;
                    if (scl && sda_d && !sda) begin
                        state <= START_HOLD;
                    end else if (scl && !sda_d && sda) begin
                        state <= STOP_HOLD;
                    end
                end
                START_HOLD: begin
                    // A data rise under a high clock is a stop, so it must not be lost.
                    if (scl && sda) begin
                        state      <= STOP_HOLD;
                        hold_count <= 6'h00;
                    end else if (!scl) begin
                        state       <= IDLE;
                        start_pulse <= !sda && hold_count > hold_threshold;
                    end else if (hold_count != 6'h3f) begin
                        hold_count <= hold_count + 6'h01;
                    end
                end
                STOP_HOLD: begin
                    if (!scl) begin
                        state <= IDLE;
                    end else if (!sda) begin
                        state      <= START_HOLD;
                        hold_count <= 6'h00;
                    end else if (hold_count > hold_threshold) begin
                        state      <= IDLE;
                        stop_pulse <= 1'b1;
                    end else if (hold_count != 6'h3f) begin
                        hold_count <= hold_count + 6'h01;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            occupied <= 1'b0;
        end else if (det_reset || stop_pulse) begin
            occupied <= 1'b0;
        end else if (start_pulse) begin
            occupied <= 1'b1;
        end
    end
endmodule

// ==== core/bct_glitch_filter.sv ====
// Glitch filter for one bus line, with bypass.
module bct_glitch_filter (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       line_in,
    input  wire logic       enable,
    input  wire logic [3:0] width,
    output logic            line_out
);
    logic [3:0] count;
    logic       held;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            held  <= 1'b1;
            count <= 4'h0;
        end else if (line_in == held) begin
            count <= 4'h0;
        end else if (count >= width) begin
            held  <= line_in;
            count <= 4'h0;
        end else begin
            count <= count + 4'h1;
        end
    end

    always_comb begin
        line_out = enable ? held : line_in;
    end
endmodule

// ==== core/bct_pkg.sv ====
// Package with register map, reset values and carriers for the bus condition timing block.
// Overview of operation
// - Writing one resets start/stop detectors.
// - Detector reset also clears bus occupied flag.
// - Glitch width field sets suppressed pulse width.
// - Prescale field, reset one, sets bus divider.
// - Filter control bit enables or bypasses filter.
// - Condition needs hold time above threshold.
// - Timing bits 7:6 reserved, read zero.
package bct_pkg;
    localparam logic [31:0] SHARED_CONTROL_ADDR     = 32'h4002_0850;
    localparam logic [31:0] BUS_TIMING_CONTROL_ADDR = 32'h4002_0854;
    localparam logic [31:0] STATUS_ADDR             = 32'h4002_0858;
    localparam logic [15:0] SHARED_CONTROL_RESET    = 16'h0000;
    localparam logic [15:0] BUS_TIMING_RESET        = 16'h0205;
    localparam int          DET_RESET_BIT           = 0;
    localparam int          GLITCH_LSB              = 12;
    localparam int          PRESCALE_LSB            = 9;
    localparam int          FILTER_BIT              = 8;
    localparam int          HOLD_LSB                = 0;
    localparam logic [15:0] TIMING_WRITE_MASK       = 16'hff3f;
    localparam int          STATUS_OCCUPIED_BIT     = 0;
    localparam int          STATUS_START_BIT        = 1;
    localparam int          STATUS_STOP_BIT         = 2;

    typedef struct packed {
        logic [3:0] glitch_width;
        logic [2:0] prescale;
        logic       filter_on;
        logic [5:0] hold_threshold;
    } bct_timing_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } bct_lines_t;
endpackage

// ==== core/bct_top.sv ====
// Top level of the bus condition timing block with its register port.
module bct_top (
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic [31:0] ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    input  wire logic        SCL_IN,
    input  wire logic        SDA_IN,
    output logic      [2:0]  PRESCALE,
    output logic             BUS_OCCUPIED,
    output logic             START_DET,
    output logic             STOP_DET
);
    logic                rst_meta;
    logic                rst_n;
    logic [1:0]          scl_sync;
    logic [1:0]          sda_sync;
    logic [15:0]         shared_control;
    bct_pkg::bct_timing_t timing;
    bct_pkg::bct_lines_t filtered;
    logic                occupied;
    logic                start_pulse;
    logic                stop_pulse;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Pins are asynchronous, so two flops precede the filter.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
        end else begin
            scl_sync <= {scl_sync[0], SCL_IN};
            sda_sync <= {sda_sync[0], SDA_IN};
        end
    end

    // Detector reset holds until software clears it.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            shared_control <= bct_pkg::SHARED_CONTROL_RESET;
        end else if (WR && ADDR == bct_pkg::SHARED_CONTROL_ADDR) begin
            shared_control <= WDATA;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            // The reserved pair is not stored, so the reset word is split around it.
            timing <= {bct_pkg::BUS_TIMING_RESET[15:8], bct_pkg::BUS_TIMING_RESET[5:0]};
        end else if (WR && ADDR == bct_pkg::BUS_TIMING_CONTROL_ADDR) begin
            timing <= {WDATA[15:8], WDATA[5:0]};
        end
    end

    bct_glitch_filter u_scl_filter (
        .clk      (CLK),
        .rst_n    (rst_n),
        .line_in  (scl_sync[1]),
        .enable   (timing.filter_on),
        .width    (timing.glitch_width),
        .line_out (filtered.scl)
    );

    bct_glitch_filter u_sda_filter (
        .clk      (CLK),
        .rst_n    (rst_n),
        .line_in  (sda_sync[1]),
        .enable   (timing.filter_on),
        .width    (timing.glitch_width),
        .line_out (filtered.sda)
    );

    bct_condition_detect u_detect (
        .clk            (CLK),
        .rst_n          (rst_n),
        .det_reset      (shared_control[bct_pkg::DET_RESET_BIT]),
        .scl            (filtered.scl),
        .sda            (filtered.sda),
        .hold_threshold (timing.hold_threshold),
        .start_pulse    (start_pulse),
        .stop_pulse     (stop_pulse),
        .occupied       (occupied)
    );

    // Outputs are registered copies; they lag the detector by one cycle.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            PRESCALE     <= bct_pkg::BUS_TIMING_RESET[11:9];
            BUS_OCCUPIED <= 1'b0;
            START_DET    <= 1'b0;
            STOP_DET     <= 1'b0;
        end else begin
            PRESCALE     <= timing.prescale;
            BUS_OCCUPIED <= occupied;
            START_DET    <= start_pulse;
            STOP_DET     <= stop_pulse;
        end
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            RDATA <= 16'h0000;
        end else if (RD) begin
            unique case (ADDR)
                bct_pkg::SHARED_CONTROL_ADDR:     RDATA <= {shared_control[15:1], 1'b0};
                bct_pkg::BUS_TIMING_CONTROL_ADDR: RDATA <= {timing[13:6], 2'b00, timing[5:0]};
                bct_pkg::STATUS_ADDR:             RDATA <= {13'h0000, stop_pulse, start_pulse, occupied};
                default:                          RDATA <= 16'h0000;
            endcase
        end else begin
            RDATA <= 16'h0000;
        end
    end
endmodule
